// >>> rtl/rswt_pkg.sv
// Constants and types shared by the radio sleep wake-up timer design files.
// Behaviour
// - Internal slow RC tick at 32.768 kHz clocks the timer unless crystal selected.
// - Periods restart automatically, so wake-ups recur while the timer stays enabled.
// - Timer enable set when sleep is entered starts counting the programmed period.
// - Expiry pulls the interrupt pin low only when the timer interrupt is enabled.
// - Interrupt enable register selects between interrupt mode and pin output mode.
// - Count high register reads the live count; reading it latches the low byte for the low register.
// - Period equals 32 times M times two to the R slow clock cycles.
// - Exponent R is five bits of the exponent register, power-on value 03h.
// - Mantissa high and low byte registers both reset to 00h.
// - Enabled interrupt: pin goes low and the main crystal is switched on.
// - Disabled interrupt: expiry only shows on the pin, operating state unchanged.
// - External crystal select releases general pin zero for the crystal.
// - External crystal select moves all slow clocking to the crystal input.
package rswt_pkg;

    // ************************************************************
    // Clock figures
    // ************************************************************
    localparam int unsigned RSWT_HCLK_HZ        = 250_000_000;
    localparam int unsigned RSWT_SLOW_HZ        = 32_768;
    localparam int unsigned RSWT_RC_DIV_CYCLES  = RSWT_HCLK_HZ / RSWT_SLOW_HZ;
    localparam int unsigned RSWT_PERIOD_SCALE   = 32;

    // ************************************************************
    // Register indices, byte address is four times the index
    // ************************************************************
    localparam logic [4:0] RSWT_IDX_STATUS1   = 5'h03;
    localparam logic [4:0] RSWT_IDX_STATUS2   = 5'h04;
    localparam logic [4:0] RSWT_IDX_IRQ_EN2   = 5'h06;
    localparam logic [4:0] RSWT_IDX_CONTROL   = 5'h07;
    localparam logic [4:0] RSWT_IDX_EXPONENT  = 5'h14;
    localparam logic [4:0] RSWT_IDX_MANT_HIGH = 5'h15;
    localparam logic [4:0] RSWT_IDX_MANT_LOW  = 5'h16;
    localparam logic [4:0] RSWT_IDX_CNT_HIGH  = 5'h17;
    localparam logic [4:0] RSWT_IDX_CNT_LOW   = 5'h18;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned RSWT_CTRL_XTAL_ON_BIT = 0;
    localparam int unsigned RSWT_CTRL_ENABLE_BIT  = 5;
    localparam int unsigned RSWT_CTRL_EXT_SEL_BIT = 6;
    localparam int unsigned RSWT_WAKE_FLAG_BIT    = 3;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [7:0] RSWT_CONTROL_RST   = 8'h01;
    localparam logic [7:0] RSWT_IRQ_EN2_RST   = 8'h00;
    localparam logic [4:0] RSWT_EXPONENT_RST  = 5'h03;
    localparam logic [7:0] RSWT_MANT_BYTE_RST = 8'h00;

    // ************************************************************
    // Operating states
    // ************************************************************
    typedef enum logic [0:0] {
        RSWT_SLEEP = 1'b0,
        RSWT_READY = 1'b1
    } rswt_state_t;

endpackage : rswt_pkg

// >>> rtl/rswt_timer_if.sv
// Interface between the register side and the wake period counter.
`timescale 1ns/10ps
`default_nettype none
interface rswt_timer_if;
    logic        tick;
    logic        run;
    logic        restart;
    logic [4:0]  exponent;
    logic [15:0] mantissa;
    logic [15:0] count;
    logic        expire;

    modport ctrl (
        output tick,
        output run,
        output restart,
        output exponent,
        output mantissa,
        input  count,
        input  expire
    );

    modport timer (
        input  tick,
        input  run,
        input  restart,
        input  exponent,
        input  mantissa,
        output count,
        output expire
    );
endinterface : rswt_timer_if
`default_nettype wire

// >>> rtl/rswt_wake_counter.sv
// Wake period counter: prescaler of 32 times two to the R slow ticks and mantissa counter.
`timescale 1ns/10ps
`default_nettype none
module rswt_wake_counter
    import rswt_pkg::*;
(
    input  wire logic   hclk,
    input  wire logic   hresetn,
    rswt_timer_if.timer tmr
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [36:0] prescale;
        logic [15:0] count;
        logic        expire;
    } rswt_cnt_state_t;

    rswt_cnt_state_t r_reg;
    rswt_cnt_state_t r_next;
    logic [36:0]     limit;

    // The prescaler is wide enough for R = 31, so no exponent value can wrap early.
    assign limit = (37'(RSWT_PERIOD_SCALE) << tmr.exponent) - 37'h1;

    always_comb begin
        r_next        = r_reg;
        r_next.expire = 1'b0;
        if (tmr.restart || !tmr.run) begin
            r_next.prescale = 37'h0;
            r_next.count    = 16'h0;
        end else if (tmr.tick) begin
            if (r_reg.prescale >= limit) begin
                r_next.prescale = 37'h0;
                // A zero mantissa never expires; the count simply wraps.
                if (tmr.mantissa != 16'h0 && r_reg.count >= tmr.mantissa - 16'h1) begin
                    r_next.count  = 16'h0;
                    r_next.expire = 1'b1;
                end else begin
                    r_next.count = r_reg.count + 16'h1;
                end
            end else begin
                r_next.prescale = r_reg.prescale + 37'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tmr.count  = r_reg.count;
    assign tmr.expire = r_reg.expire;

endmodule : rswt_wake_counter
`default_nettype wire

// >>> rtl/rswt_wake_timer.sv
// Top of the radio sleep wake-up timer with its AHB-Lite register slave.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module rswt_wake_timer
    import rswt_pkg::*;
#(
    parameter int unsigned RC_DIV_CYCLES = RSWT_RC_DIV_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             interrupt_request_pin_n,
    output logic             main_crystal_enable,
    output logic             slow_clock_out,
    input  wire logic        general_pin_zero_in,
    output logic             general_pin_zero_out,
    output logic             general_pin_zero_oe
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        rswt_state_t state;
        logic        timer_enable;
        logic        ext_select;
        logic        irq_enable;
        logic        wake_flag;
        logic        armed;
        logic        restart;
        logic [4:0]  exponent;
        logic [15:0] mantissa;
        logic [7:0]  low_latch;
        logic [4:0]  index;
        logic        rd_pend;
        logic        wr_pend;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        irq_n;
        logic        xtal_en;
        logic        pin_out;
        logic        pin_oe;
        logic        slow_out;
        logic        slow_tick;
        logic [12:0] rc_cnt;
        logic        ext_prev;
    } rswt_top_state_t;

    rswt_top_state_t r_reg;
    rswt_top_state_t r_next;

    rswt_timer_if tif ();

    logic        addr_ok;
    logic        take;
    logic [7:0]  wbyte;
    logic        wake_set;
    logic [12:0] rc_last;

    // ************************************************************
    // Read data selection
    // ************************************************************
    function automatic logic [7:0] rswt_read_byte(
        input logic [4:0]      idx,
        input rswt_top_state_t s,
        input logic [15:0]     cnt
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            RSWT_IDX_STATUS2: begin
                v[RSWT_WAKE_FLAG_BIT] = s.wake_flag;
            end
            RSWT_IDX_IRQ_EN2: begin
                v[RSWT_WAKE_FLAG_BIT] = s.irq_enable;
            end
            RSWT_IDX_CONTROL: begin
                v[RSWT_CTRL_XTAL_ON_BIT] = (s.state == RSWT_READY);
                v[RSWT_CTRL_ENABLE_BIT]  = s.timer_enable;
                v[RSWT_CTRL_EXT_SEL_BIT] = s.ext_select;
            end
            RSWT_IDX_EXPONENT: begin
                v[4:0] = s.exponent;
            end
            RSWT_IDX_MANT_HIGH: begin
                v = s.mantissa[15:8];
            end
            RSWT_IDX_MANT_LOW: begin
                v = s.mantissa[7:0];
            end
            RSWT_IDX_CNT_HIGH: begin
                v = cnt[15:8];
            end
            RSWT_IDX_CNT_LOW: begin
                v = s.low_latch;
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction : rswt_read_byte

    // ************************************************************
    // Bus decode
    // ************************************************************
    assign addr_ok  = (haddr[31:7] == 25'h0) && (haddr[1:0] == 2'b00);
    assign take     = hsel && hready && htrans[1];
    assign wbyte    = hwdata[7:0];
    assign wake_set = tif.expire;
    assign rc_last  = 13'(RC_DIV_CYCLES - 1);

    always_comb begin
        r_next           = r_reg;
        r_next.restart   = 1'b0;
        r_next.slow_tick = 1'b0;
        r_next.ext_prev  = general_pin_zero_in;

        // ********************************************************
        // Slow clock source
        // ********************************************************
        if (r_reg.rc_cnt >= rc_last) begin
            r_next.rc_cnt = 13'h0;
        end else begin
            r_next.rc_cnt = r_reg.rc_cnt + 13'h1;
        end
        if (r_reg.ext_select) begin
            r_next.slow_tick = general_pin_zero_in && !r_reg.ext_prev;
            r_next.slow_out  = general_pin_zero_in;
        end else begin
            r_next.slow_tick = (r_reg.rc_cnt >= rc_last);
            r_next.slow_out  = (r_reg.rc_cnt < 13'(RC_DIV_CYCLES / 2));
        end

        // ********************************************************
        // Address phase
        // ********************************************************
        if (take) begin
            r_next.index   = addr_ok ? haddr[6:2] : 5'h1f;
            r_next.wr_pend = hwrite;
            r_next.rd_pend = !hwrite;
            // One wait state on reads covers the cycle that registers the read data.
            r_next.hreadyout = hwrite;
        end else begin
            r_next.wr_pend = 1'b0;
            r_next.rd_pend = 1'b0;
            r_next.hreadyout = 1'b1;
        end

        // ********************************************************
        // Write data phase
        // ********************************************************
        if (r_reg.wr_pend) begin
            unique case (r_reg.index)
                RSWT_IDX_IRQ_EN2: begin
                    r_next.irq_enable = wbyte[RSWT_WAKE_FLAG_BIT];
                end
                RSWT_IDX_CONTROL: begin
                    r_next.timer_enable = wbyte[RSWT_CTRL_ENABLE_BIT];
                    r_next.ext_select   = wbyte[RSWT_CTRL_EXT_SEL_BIT];
                    if (wbyte[RSWT_CTRL_XTAL_ON_BIT]) begin
                        r_next.state = RSWT_READY;
                    end else begin
                        r_next.state = RSWT_SLEEP;
                        if (wbyte[RSWT_CTRL_ENABLE_BIT] && !r_reg.armed) begin
                            r_next.armed   = 1'b1;
                            r_next.restart = 1'b1;
                        end
                    end
                    if (!wbyte[RSWT_CTRL_ENABLE_BIT]) begin
                        r_next.armed = 1'b0;
                    end
                end
                RSWT_IDX_EXPONENT: begin
                    r_next.exponent = wbyte[4:0];
                end
                RSWT_IDX_MANT_HIGH: begin
                    r_next.mantissa[15:8] = wbyte;
                end
                RSWT_IDX_MANT_LOW: begin
                    r_next.mantissa[7:0] = wbyte;
                end
                default: begin
                end
            endcase
        end

        // ********************************************************
        // Read data phase with its side effects
        // ********************************************************
        if (r_reg.rd_pend) begin
            r_next.hrdata = {24'h0, rswt_read_byte(r_reg.index, r_reg, tif.count)};
            if (r_reg.index == RSWT_IDX_CNT_HIGH) begin
                r_next.low_latch = tif.count[7:0];
            end
            if (r_reg.index == RSWT_IDX_STATUS2) begin
                r_next.wake_flag = 1'b0;
            end
        end

        // ********************************************************
        // Expiry handling; a new expiry beats a clearing read
        // ********************************************************
        if (wake_set) begin
            r_next.wake_flag = 1'b1;
            if (r_reg.irq_enable) begin
                r_next.state = RSWT_READY;
            end
        end

        r_next.irq_n   = !(r_next.wake_flag && r_next.irq_enable);
        r_next.xtal_en = (r_next.state == RSWT_READY);
        // Without interrupt enabled the event only shows on the pin.
        r_next.pin_out = r_next.wake_flag && !r_next.irq_enable;
        r_next.pin_oe  = !r_next.ext_select;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg              <= '0;
            r_reg.state        <= RSWT_READY;
            r_reg.timer_enable <= RSWT_CONTROL_RST[RSWT_CTRL_ENABLE_BIT];
            r_reg.ext_select   <= RSWT_CONTROL_RST[RSWT_CTRL_EXT_SEL_BIT];
            r_reg.irq_enable   <= RSWT_IRQ_EN2_RST[RSWT_WAKE_FLAG_BIT];
            r_reg.exponent     <= RSWT_EXPONENT_RST;
            r_reg.mantissa     <= {RSWT_MANT_BYTE_RST, RSWT_MANT_BYTE_RST};
            r_reg.hreadyout    <= 1'b1;
            r_reg.irq_n        <= 1'b1;
            r_reg.xtal_en      <= 1'b1;
            r_reg.pin_oe       <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ************************************************************
    // Counter and outputs
    // ************************************************************
    assign tif.tick     = r_reg.slow_tick;
    assign tif.run      = r_reg.armed && r_reg.timer_enable;
    assign tif.restart  = r_reg.restart;
    assign tif.exponent = r_reg.exponent;
    assign tif.mantissa = r_reg.mantissa;

    rswt_wake_counter u_counter (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tmr     (tif.timer)
    );

    assign hrdata                  = r_reg.hrdata;
    assign hreadyout               = r_reg.hreadyout;
    assign hresp                   = 1'b0;
    assign interrupt_request_pin_n = r_reg.irq_n;
    assign main_crystal_enable     = r_reg.xtal_en;
    assign slow_clock_out          = r_reg.slow_out;
    assign general_pin_zero_out    = r_reg.pin_out;
    assign general_pin_zero_oe     = r_reg.pin_oe;

endmodule : rswt_wake_timer
`default_nettype wire

// >>> testbench/rswt_wake_timer_props.sv
// Checker of the bus and wake-up outputs of the wake-up timer.
`timescale 1ns/10ps
`default_nettype none
module rswt_wake_timer_props (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        interrupt_request_pin_n,
    input wire logic        main_crystal_enable,
    input wire logic        general_pin_zero_out
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic take;
    assign take = hsel && hready && htrans[1];

    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("slave response not okay");
    chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write inserted a wait state");
    chk_wait_single: assert property (!hreadyout |=> hreadyout)
        else $error("wait state longer than one cycle");
    chk_rdata_upper: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_irq_xtal: assert property ($fell(interrupt_request_pin_n) |-> ##[0:2] main_crystal_enable)
        else $error("interrupt without crystal enable");
    chk_irq_vs_pin: assert property (!interrupt_request_pin_n |-> !general_pin_zero_out)
        else $error("interrupt and pin output both active");
    chk_pin_keeps: assert property ($rose(general_pin_zero_out) |-> $stable(main_crystal_enable))
        else $error("pin mode expiry changed state");
    // The request only goes away after the host has touched the bus.
    chk_irq_release: assert property ($rose(interrupt_request_pin_n) |->
        $past(take, 1) || $past(take, 2) || $past(take, 3))
        else $error("interrupt released without host access");

    cover property (take && !hwrite);
    cover property ($fell(interrupt_request_pin_n));
    cover property ($rose(general_pin_zero_out));
endmodule : rswt_wake_timer_props

bind rswt_wake_timer rswt_wake_timer_props i_props (
    .hclk                    (hclk),
    .hresetn                 (hresetn),
    .hsel                    (hsel),
    .htrans                  (htrans),
    .hwrite                  (hwrite),
    .hready                  (hready),
    .hrdata                  (hrdata),
    .hreadyout               (hreadyout),
    .hresp                   (hresp),
    .interrupt_request_pin_n (interrupt_request_pin_n),
    .main_crystal_enable     (main_crystal_enable),
    .general_pin_zero_out    (general_pin_zero_out)
);
`default_nettype wire

// >>> testbench/rswt_host_model.sv
// Host model: AHB-Lite master of the registers and the external slow crystal.
`timescale 1ns/10ps
`default_nettype none
module rswt_host_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    output logic             xtal
);
    // ************************************************************
    // Bus master and crystal
    // ************************************************************
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
    end

    int xc = 0;

    // A crystal oscillates freely, so it never stands still between expiries.
    always @(posedge hclk) begin
        xc   <= (xc == 9) ? 0 : xc + 1;
        xtal <= (xc >= 5);
    end

    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : bus
endmodule : rswt_host_model
`default_nettype wire

// >>> testbench/rswt_wake_timer_tb.sv
// Self-checking testbench of the radio sleep wake-up timer.
`timescale 1ns/10ps
`default_nettype none
module rswt_wake_timer_tb;
    import rswt_pkg::*;
    localparam int DIV = 4;
    localparam int XT  = 10;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq_n;
    logic        xtal_en;
    logic        slow_out;
    logic        xtal;
    logic        pin_out;
    logic        pin_oe;
    logic [7:0]  mdl [32];
    logic [31:0] adr [7];
    logic [31:0] q;
    logic [31:0] q2;
    int          err_count;
    int          check_count;
    int          cyc = 0;
    int          t1;
    int          t2;
    int          seed;

    rswt_wake_timer #(.RC_DIV_CYCLES(DIV)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .interrupt_request_pin_n(irq_n), .main_crystal_enable(xtal_en),
        .slow_clock_out(slow_out), .general_pin_zero_in(xtal),
        .general_pin_zero_out(pin_out), .general_pin_zero_oe(pin_oe));
    rswt_host_model i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .xtal(xtal));

    always #2 hclk = ~hclk;
    always @(posedge hclk) cyc <= cyc + 1;

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // The model keeps only the read-write registers; read-only ones stay zero.
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        i_host.bus(a, 1'b1, {24'h0, d}, q);
        if (a == 32'h50) mdl[20] = {3'h0, d[4:0]};
        if (a == 32'h54 || a == 32'h58) mdl[a[6:2]] = d;
        if (a == 32'h18) mdl[6] = d & 8'h08;
    endtask : wr

    task automatic rd_chk(input logic [31:0] a);
        logic [31:0] v;
        i_host.bus(a, 1'b0, 32'h0, v);
        chk(v, (a[31:7] == 0) ? {24'h0, mdl[a[6:2]]} : 32'h0);
    endtask : rd_chk

    task automatic rd_is(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] v;
        i_host.bus(a, 1'b0, 32'h0, v);
        chk(v, e);
    endtask : rd_is

    // Counts rising edges of the slow clock output over n bus clocks.
    task automatic slow_edges(input int n, input int want);
        int   e;
        logic p;
        e = 0;
        @(posedge hclk);
        p = slow_out;
        repeat (n) begin
            @(posedge hclk);
            if (slow_out && !p) e++;
            p = slow_out;
        end
        chk(32'(e), 32'(want));
    endtask : slow_edges

    task automatic wait_ev(input int sel, output int at);
        int n;
        n = 0;
        while (n < 3000 && (sel == 0 ? irq_n !== 1'b0 : pin_out !== 1'b1)) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 3000) begin
            err_count++;
            $display("unexpected %0t wait for expiry timed out", $time);
        end
        at = cyc;
    endtask : wait_ev

    task automatic end_sim();
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    initial begin
        #(4 * 20000);
        err_count++;
        end_sim();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        seed = 32'h24d3;
        err_count = 0;
        check_count = 0;
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[20] = 8'h03;
        adr = '{32'h50, 32'h54, 32'h58, 32'h18, 32'h5c, 32'h7c, 32'h100};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        slow_edges(40, 40 / DIV);
        rd_is(32'h1c, 32'h01);
        foreach (adr[j]) rd_chk(adr[j]);
        for (int i = 0; i < 4; i++) begin
            foreach (adr[j]) begin
                wr(adr[j], 8'($random(seed)));
                rd_chk(adr[j]);
            end
        end
        // Interrupt mode with M of 2 and R of 0 from the RC tick.
        wr(32'h50, 8'h00);
        wr(32'h54, 8'h00);
        wr(32'h58, 8'h02);
        wr(32'h18, 8'h08);
        wr(32'h1c, 8'h20);
        repeat (2) @(posedge hclk);
        chk({31'h0, xtal_en}, 32'h0);
        wait_ev(0, t1);
        repeat (2) @(posedge hclk);
        chk({31'h0, xtal_en}, 32'h1);
        rd_is(32'h10, 32'h08);
        rd_is(32'h0c, 32'h00);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq_n}, 32'h1);
        i_host.bus(32'h5c, 1'b0, 32'h0, q);
        i_host.bus(32'h60, 1'b0, 32'h0, q2);
        chk(q, 32'h0);
        chk(32'(q2 < 2), 32'h1);
        wait_ev(0, t2);
        chk(32'(t2 - t1), 32'(RSWT_PERIOD_SCALE * 2 * DIV));
        rd_is(32'h10, 32'h08);
        // Pin output mode: expiry leaves the sleeping state alone.
        wr(32'h18, 8'h00);
        wr(32'h1c, 8'h20);
        wait_ev(1, t1);
        chk({29'h0, pin_oe, xtal_en, irq_n}, 32'h5);
        rd_is(32'h10, 32'h08);
        // External slow crystal on the general pin.
        wr(32'h1c, 8'h41);
        repeat (2) @(posedge hclk);
        chk({31'h0, pin_oe}, 32'h0);
        slow_edges(40, 40 / XT);
        wr(32'h1c, 8'h60);
        wait_ev(1, t1);
        rd_is(32'h10, 32'h08);
        wait_ev(1, t2);
        chk(32'(t2 - t1), 32'(RSWT_PERIOD_SCALE * 2 * XT));
        end_sim();
    end
endmodule : rswt_wake_timer_tb
`default_nettype wire
